// ==== core/tick_pkg.sv ====
// constants, register map and reset values of the system tick down counter
//
// Notes on behaviour
// - 24-bit wrapping down-counter; writes clear it
// - enabled, count decrements by one each clock
// - edge after zero reloads from reload register
// - zero-reached flag sets on transition to zero
// - reading the status register clears the flag
// - current value after reset carries no promise
// - zero reload holds count at zero
package tick_pkg;

    // ==========================================================
    // widths
    localparam int COUNT_W = 24;
    localparam int ADDR_W  = 12;
    localparam int DATA_W  = 32;

    // ==========================================================
    // register offsets (byte addresses, one aligned word each)
    localparam logic [ADDR_W-1:0] OFF_CTRL    = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_RELOAD  = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CURRENT = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 12'h00c;
    localparam logic [ADDR_W-1:0] OFF_MASK    = 12'h010;

    // ==========================================================
    // field positions
    localparam int CTRL_ENABLE_BIT  = 0;
    localparam int STAT_ZERO_BIT    = 0;
    localparam int STAT_EVENT_BIT   = 1;
    localparam int STAT_W           = 2;

    // ==========================================================
    // values after reset, and the one-count decrement step
    localparam logic [COUNT_W-1:0] RST_COUNT  = 24'h000000;
    localparam logic [COUNT_W-1:0] RST_RELOAD = 24'h000000;
    localparam logic [STAT_W-1:0]  RST_STAT   = 2'h0;
    localparam logic [STAT_W-1:0]  RST_MASK   = 2'h0;
    localparam logic [DATA_W-1:0]  RST_RDATA  = 32'h00000000;
    localparam logic [COUNT_W-1:0] COUNT_ONE  = 24'h000001;

endpackage

// ==== core/tick_reset_sync.sv ====
// two-stage release synchroniser for the active-low reset
`timescale 1ns/1ps
module tick_reset_sync
    import tick_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst_async,
    output logic      rst_n
);

    typedef struct packed {
        logic first;
        logic second;
    } sync_s;

    sync_s st;
    sync_s next_st;

    // ==========================================================
    // release path: first stage feeds only the second
    always_comb
    begin
        next_st        = st;
        next_st.first  = 1'b1;
        next_st.second = st.first;
    end

    // assert at once, release two edges later; not frozen by the clock enable
    always_ff @(posedge clk or negedge nrst_async)
    begin
        if (!nrst_async)
            st <= '0;
        else
            st <= next_st;
    end

    assign rst_n = st.second;

endmodule // tick_reset_sync

// ==== core/tick_down_core.sv ====
// 24-bit decrementing counter with reload on the edge after zero
`timescale 1ns/1ps
module tick_down_core
    import tick_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               ce,
    input  wire logic               enable,
    input  wire logic               clear,
    input  wire logic [COUNT_W-1:0] reload,
    output logic      [COUNT_W-1:0] count,
    output logic                    zero_event
);

    typedef struct packed {
        logic [COUNT_W-1:0] count;
    } core_s;

    core_s st;
    core_s next_st;

    // ==========================================================
    // count, wrap and clear
    always_comb
    begin
        next_st = st;
        if (clear)
            next_st.count = RST_COUNT;
        else if (enable)
        begin
            if (st.count == RST_COUNT)
                next_st.count = reload;
            else
                next_st.count = st.count - COUNT_ONE;
        end
        // disabled: value stands untouched
    end

    // one-cycle mark of the step that lands on zero
    assign zero_event = enable && !clear && (st.count == COUNT_ONE);

    // reset value is a convenience only; software must not rely on it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '{count: RST_COUNT};
        else if (ce)
            st <= next_st;
    end

    assign count = st.count;

endmodule // tick_down_core

// ==== core/system_tick_timer.sv ====
// system tick timer: apb register slave, flags, interrupt and counter
`timescale 1ns/1ps
module system_tick_timer
    import tick_pkg::*;
(
    input  wire logic              CLK_SYS,
    input  wire logic              NRST,
    input  wire logic              CE,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [DATA_W-1:0] PWDATA,
    output logic      [DATA_W-1:0] PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    output logic                   IRQ
);

    // ==========================================================
    // state
    typedef struct packed {
        logic [DATA_W-1:0]  rdata;
        logic               ready;
        logic               slverr;
        logic               enable;
        logic [COUNT_W-1:0] reload;
        logic [STAT_W-1:0]  status;
        logic [STAT_W-1:0]  mask;
        logic               irq;
    } regs_s;

    regs_s st;
    regs_s next_st;

    logic               rst_n;
    logic [COUNT_W-1:0] count;
    logic               zero_event;
    logic               setup;
    logic               ack;
    logic               wr_ack;
    logic               rd_ack;
    logic               cur_clr;
    logic               wr_status;
    logic               rd_status;
    logic [STAT_W-1:0]  stat_clr;

    // ==========================================================
    // address decode, used by the setup phase only; the access phase uses the stored error
    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        is_mapped = (addr == OFF_CTRL) || (addr == OFF_RELOAD) ||
                    (addr == OFF_CURRENT) || (addr == OFF_STATUS) ||
                    (addr == OFF_MASK);
    endfunction

    // ==========================================================
    // leaf instances
    tick_reset_sync u_reset_sync (
        .clk        (CLK_SYS),
        .nrst_async (NRST),
        .rst_n      (rst_n)
    );

    tick_down_core u_core (
        .clk        (CLK_SYS),
        .rst_n      (rst_n),
        .ce         (CE),
        .enable     (st.enable),
        .clear      (cur_clr),
        .reload     (st.reload),
        .count      (count),
        .zero_event (zero_event)
    );

    // ==========================================================
    // bus phases: ready is raised one cycle after setup, so no wait states
    assign setup     = PSEL && !PENABLE;
    assign ack       = PSEL && PENABLE && st.ready;
    assign wr_ack    = ack && PWRITE && !st.slverr;
    assign rd_ack    = ack && !PWRITE && !st.slverr;
    assign cur_clr   = wr_ack && (PADDR == OFF_CURRENT);
    assign wr_status = wr_ack && (PADDR == OFF_STATUS);
    assign rd_status = rd_ack && (PADDR == OFF_STATUS);

    // flag clears: a read drops only the zero flag, and only if the read really returned it as one,
    // so a flag raised between setup and access is not lost
    always_comb
    begin
        stat_clr = '0;
        if (rd_status)
            stat_clr[STAT_ZERO_BIT] = st.rdata[STAT_ZERO_BIT];
        if (wr_status)
            stat_clr = stat_clr | PWDATA[STAT_W-1:0];
        if (cur_clr)
            stat_clr[STAT_ZERO_BIT] = 1'b1;
    end

    // ==========================================================
    // next register state
    always_comb
    begin
        next_st = st;

        // read data and error are captured in the setup cycle
        next_st.ready = setup;
        if (setup)
        begin
            next_st.slverr = !is_mapped(PADDR);
            next_st.rdata  = RST_RDATA;
            if (!PWRITE)
            begin
                case (PADDR)
                    OFF_CTRL:    next_st.rdata[CTRL_ENABLE_BIT] = st.enable;
                    OFF_RELOAD:  next_st.rdata[COUNT_W-1:0] = st.reload;
                    OFF_CURRENT: next_st.rdata[COUNT_W-1:0] = count;
                    OFF_STATUS:  next_st.rdata[STAT_W-1:0] = st.status;
                    OFF_MASK:    next_st.rdata[STAT_W-1:0] = st.mask;
                    default:     next_st.rdata = RST_RDATA;
                endcase
            end
        end
        else if (!PSEL)
        begin
            next_st.slverr = 1'b0;
        end

        // writes take effect at the access edge only
        if (wr_ack)
        begin
            case (PADDR)
                OFF_CTRL:   next_st.enable = PWDATA[CTRL_ENABLE_BIT];
                OFF_RELOAD: next_st.reload = PWDATA[COUNT_W-1:0];
                OFF_MASK:   next_st.mask = PWDATA[STAT_W-1:0];
                default:    next_st.enable = st.enable;
            endcase
        end

        // sticky flags: a new zero event beats any clear in the same cycle
        next_st.status = st.status & ~stat_clr;
        if (zero_event)
            next_st.status = next_st.status | {STAT_W{1'b1}};

        // level interrupt from unmasked status
        next_st.irq = |(next_st.status & next_st.mask);
    end

    // ==========================================================
    // registers; the clock enable freezes everything but the reset path
    always_ff @(posedge CLK_SYS or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '{rdata:  RST_RDATA,
                    ready:  1'b0,
                    slverr: 1'b0,
                    enable: 1'b0,
                    reload: RST_RELOAD,
                    status: RST_STAT,
                    mask:   RST_MASK,
                    irq:    1'b0};
        end
        else if (CE)
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // outputs, all straight from flops
    assign PRDATA  = st.rdata;
    assign PREADY  = st.ready;
    assign PSLVERR = st.slverr;
    assign IRQ     = st.irq;

    // ==========================================================
    // checks on counter behaviour
    AST_DECREMENT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && st.enable && !cur_clr && count != RST_COUNT
        |=> count == $past(count) - COUNT_ONE)
        else $error("count did not step down by one");

    AST_WRAP_RELOAD: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && st.enable && !cur_clr && count == RST_COUNT
        |=> count == $past(st.reload))
        else $error("count did not reload after zero");

    AST_WRITE_CLEARS_COUNT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && wr_ack && PADDR == OFF_CURRENT
        |=> count == RST_COUNT)
        else $error("current value write did not clear count");

    AST_ZERO_RELOAD_HOLDS: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && st.enable && !cur_clr && count == RST_COUNT && st.reload == RST_RELOAD
        && !(wr_ack && PADDR == OFF_RELOAD)
        |=> count == RST_COUNT ##1 count == RST_COUNT)
        else $error("zero reload did not hold count at zero");

    AST_DISABLED_HOLDS: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && !st.enable && !cur_clr
        |=> $stable(count))
        else $error("disabled counter changed value");

    // ==========================================================
    // checks on flag, bus and interrupt
    AST_FLAG_SETS_AT_ZERO: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && st.enable && !cur_clr && count == COUNT_ONE
        |=> st.status[STAT_ZERO_BIT] && count == RST_COUNT)
        else $error("flag not set on reaching zero");

    AST_READ_CLEARS_FLAG: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && rd_status && st.rdata[STAT_ZERO_BIT] && !zero_event
        |=> !st.status[STAT_ZERO_BIT])
        else $error("status read did not clear flag");

    AST_WRITE_CLEARS_FLAG: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && cur_clr
        |=> !st.status[STAT_ZERO_BIT])
        else $error("current value write did not clear flag");

    AST_SET_BEATS_CLEAR: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && zero_event && (rd_status || wr_status)
        |=> st.status == {STAT_W{1'b1}})
        else $error("clear won over a new zero event");

    AST_ZERO_ANSWER: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && setup |=> PREADY && PSLVERR == !is_mapped($past(PADDR)))
        else $error("setup not answered on the next cycle");

    AST_IRQ_LEVEL: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        IRQ == |(st.status & st.mask))
        else $error("interrupt does not follow masked status");

    // ==========================================================
    // checks on bus timing, write landing, flags and clock enable
    AST_READY_ONLY_AFTER_SETUP: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && !setup
        |=> !PREADY)
        else $error("ready raised without a setup cycle");

    AST_ERROR_CLEARS_IDLE: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && !PSEL
        |=> !PSLVERR)
        else $error("error flag stayed up on an idle bus");

    AST_READ_DATA_STANDS: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && !setup
        |=> $stable(PRDATA))
        else $error("read data changed outside a setup cycle");

    AST_CURRENT_READ_DATA: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && setup && !PWRITE && PADDR == OFF_CURRENT
        |=> PRDATA == 32'($past(count)))
        else $error("current value read returned a wrong count");

    AST_STATUS_READ_DATA: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && setup && !PWRITE && PADDR == OFF_STATUS
        |=> PRDATA == 32'($past(st.status)))
        else $error("status read returned wrong flags");

    AST_ENABLE_WRITE_LANDS: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && wr_ack && PADDR == OFF_CTRL
        |=> st.enable == $past(PWDATA[CTRL_ENABLE_BIT]))
        else $error("control write did not land");

    AST_RELOAD_WRITE_LANDS: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && wr_ack && PADDR == OFF_RELOAD
        |=> st.reload == $past(PWDATA[COUNT_W-1:0]))
        else $error("reload write did not land");

    AST_ERROR_NO_EFFECT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && ack && st.slverr
        |=> $stable(st.enable) && $stable(st.reload) && $stable(st.mask))
        else $error("refused transfer changed a register");

    AST_W1C_CLEARS: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && wr_status && !zero_event
        |=> (st.status & $past(PWDATA[STAT_W-1:0])) == '0)
        else $error("status write did not clear the written ones");

    AST_FLAG_ONLY_ON_EVENT: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && !zero_event
        |=> !$rose(st.status[STAT_ZERO_BIT]))
        else $error("flag rose without a step to zero");

    AST_CE_FREEZES: assert property (@(posedge CLK_SYS) disable iff (!rst_n)
        !CE
        |=> $stable(count) && $stable(st.status) && $stable(PREADY) && $stable(IRQ))
        else $error("state moved while the clock enable was low");

    // ==========================================================
    // scenarios worth seeing
    COV_WRAP: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
        CE && st.enable && count == RST_COUNT && st.reload != RST_RELOAD);
    COV_FLAG_READ: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
        rd_status && st.rdata[STAT_ZERO_BIT]);
    COV_IRQ: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
        $rose(IRQ));
    COV_ZERO_RELOAD: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
        st.enable && count == RST_COUNT && st.reload == RST_RELOAD);
    COV_CE_FREEZE: cover property (@(posedge CLK_SYS) disable iff (!rst_n)
        !CE && st.enable);

endmodule // system_tick_timer

// ==== test/system_tick_timer_bench.sv ====
// self-checking apb testbench of the system tick timer
`timescale 1ns/1ps
module system_tick_timer_bench
    import tick_pkg::*;
;
    logic              CLK_SYS;
    logic              NRST;
    logic              CE;
    logic              PSEL;
    logic              PENABLE;
    logic              PWRITE;
    logic [ADDR_W-1:0] PADDR;
    logic [DATA_W-1:0] PWDATA;
    logic [DATA_W-1:0] PRDATA;
    logic              PREADY;
    logic              PSLVERR;
    logic              IRQ;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] v1;
    logic              er;
    int                mismatches;
    int                tests_run;

    system_tick_timer dut_u (
        .CLK_SYS (CLK_SYS),
        .NRST    (NRST),
        .CE      (CE),
        .PSEL    (PSEL),
        .PENABLE (PENABLE),
        .PWRITE  (PWRITE),
        .PADDR   (PADDR),
        .PWDATA  (PWDATA),
        .PRDATA  (PRDATA),
        .PREADY  (PREADY),
        .PSLVERR (PSLVERR),
        .IRQ     (IRQ)
    );

    // ==========================================================
    // clock, 100 ns period
    initial
    begin
        CLK_SYS = 1'b0;
        forever #50 CLK_SYS = ~CLK_SYS;
    end

    // ==========================================================
    // verdict and comparison helpers
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge CLK_SYS);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLK_SYS);
        PENABLE <= 1'b1;
        do
        begin
            @(posedge CLK_SYS);
            n++;
        end
        while (PREADY !== 1'b1 && n < 20);
        // a slave that never answers ends the run
        if (PREADY !== 1'b1)
        begin
            mismatches++;
            final_report;
        end
        else
        begin
            rd = PRDATA;
            er = PSLVERR;
            PSEL    <= 1'b0;
            PENABLE <= 1'b0;
        end
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        apb(1'b1, a, d);
        check(32'(er), 32'h0);
    endtask

    task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic ee);
        apb(1'b0, a, 32'h0);
        check(rd, e);
        check(32'(er), 32'(ee));
    endtask

    // three counter edges between two setup edges, period reload+1
    function automatic logic [DATA_W-1:0] step3(input logic [DATA_W-1:0] v);
        for (int i = 0; i < 3; i++)
            v = (v == 32'h0) ? 32'h4 : v - 32'h1;
        return v;
    endfunction

    // ==========================================================
    // main sequence
    initial
    begin
        NRST = 1'b0; CE = 1'b1; PSEL = 1'b0; PENABLE = 1'b0;
        PWRITE = 1'b0; PADDR = '0; PWDATA = '0;
        mismatches = 0;
        tests_run = 0;
        repeat (6) @(posedge CLK_SYS);
        NRST <= 1'b1;
        repeat (4) @(posedge CLK_SYS);
        // reset values; current value is not assumed
        rdchk(OFF_CTRL, 32'h0, 1'b0);
        rdchk(OFF_RELOAD, 32'h0, 1'b0);
        rdchk(OFF_STATUS, 32'h0, 1'b0);
        rdchk(OFF_MASK, 32'h0, 1'b0);
        check(32'(IRQ), 32'h0);
        $display("test reset done");
        // width, unmapped and misaligned places
        wr(OFF_RELOAD, 32'hffffffff);
        rdchk(OFF_RELOAD, 32'h00ffffff, 1'b0);
        apb(1'b1, 12'h014, 32'h1);
        check(32'(er), 32'h1);
        rdchk(12'h014, 32'h0, 1'b1);
        rdchk(12'h006, 32'h0, 1'b1);
        // a write clears rather than loads
        wr(OFF_CURRENT, 32'h5a);
        rdchk(OFF_CURRENT, 32'h0, 1'b0);
        $display("test map done");
        // decrement by one per clock, frozen while ce is low
        wr(OFF_RELOAD, 32'h1000);
        wr(OFF_CURRENT, 32'h0);
        wr(OFF_CTRL, 32'h1);
        apb(1'b0, OFF_CURRENT, 32'h0);
        v1 = rd;
        rdchk(OFF_CURRENT, v1 - 32'h3, 1'b0);
        v1 = rd;
        CE <= 1'b0;
        repeat (10) @(posedge CLK_SYS);
        CE <= 1'b1;
        rdchk(OFF_CURRENT, v1 - 32'h3, 1'b0);
        wr(OFF_CTRL, 32'h0);
        apb(1'b0, OFF_CURRENT, 32'h0);
        v1 = rd;
        repeat (5) @(posedge CLK_SYS);
        rdchk(OFF_CURRENT, v1, 1'b0);
        // clearing a held nonzero count, not only a zero one
        wr(OFF_CURRENT, 32'h5a);
        rdchk(OFF_CURRENT, 32'h0, 1'b0);
        $display("test count done");
        // wrap to reload over several periods
        wr(OFF_RELOAD, 32'h4);
        wr(OFF_CURRENT, 32'h0);
        wr(OFF_CTRL, 32'h1);
        apb(1'b0, OFF_CURRENT, 32'h0);
        v1 = rd;
        for (int i = 0; i < 6; i++)
        begin
            v1 = step3(v1);
            rdchk(OFF_CURRENT, v1, 1'b0);
        end
        // clears three edges apart; the third lands on a step to zero
        wr(OFF_STATUS, 32'h3);
        wr(OFF_STATUS, 32'h3);
        wr(OFF_STATUS, 32'h3);
        wr(OFF_CTRL, 32'h0);
        // sticky flags, read clear and interrupt
        rdchk(OFF_STATUS, 32'h3, 1'b0);
        rdchk(OFF_STATUS, 32'h2, 1'b0);
        wr(OFF_MASK, 32'h2);
        repeat (2) @(posedge CLK_SYS);
        check(32'(IRQ), 32'h1);
        wr(OFF_STATUS, 32'h2);
        repeat (2) @(posedge CLK_SYS);
        check(32'(IRQ), 32'h0);
        rdchk(OFF_STATUS, 32'h0, 1'b0);
        $display("test flags done");
        // current-value write drops a pending zero flag
        wr(OFF_RELOAD, 32'h1);
        wr(OFF_CTRL, 32'h1);
        wr(OFF_CTRL, 32'h0);
        wr(OFF_CURRENT, 32'h0);
        rdchk(OFF_STATUS, 32'h2, 1'b0);
        wr(OFF_STATUS, 32'h3);
        // zero reload parks the count without new events
        wr(OFF_RELOAD, 32'h3);
        wr(OFF_CTRL, 32'h1);
        wr(OFF_RELOAD, 32'h0);
        repeat (10) @(posedge CLK_SYS);
        rdchk(OFF_CURRENT, 32'h0, 1'b0);
        rdchk(OFF_STATUS, 32'h3, 1'b0);
        wr(OFF_STATUS, 32'h2);
        repeat (5) @(posedge CLK_SYS);
        rdchk(OFF_STATUS, 32'h0, 1'b0);
        $display("test reload zero done");
        final_report;
    end
endmodule // system_tick_timer_bench
